// ---- rtl/eif_map.svh ----
// eif register offsets, field positions and reset values
// What this block does
// - pin function 0 to 1, pin low, falling sense: set that pin's flag
// - pin function 1 to 0, pin low, rising sense: set that pin's flag
// - wakeup function 0 to 1 while pin low sets that wakeup flag
// - chosen event edge sets event flag while event enable is one
// - flag clear right after a port mode access is ignored
// - request write clears only positions written zero, ones keep value
// - flag set after a read is still cleared by a later zero write
// - word access forces address bit zero low; stack is word only
// - condition codes saved as full word, restored from even byte
// - written zero clears a set flag; flags reset to zero
// - edge select zero senses falling edge, one senses rising edge
`ifndef EIF_MAP_SVH
`define EIF_MAP_SVH

// register offsets
`define EIF_A_REQ1   8'h00
`define EIF_A_WKREQ  8'h01
`define EIF_A_PMB    8'h02
`define EIF_A_PM2    8'h03
`define EIF_A_PM5    8'h04
`define EIF_A_EDGE   8'h05
`define EIF_A_AEDGE  8'h06
`define EIF_A_IEN1   8'h07
`define EIF_A_WKEDGE 8'h08
`define EIF_A_STAT   8'h09
`define EIF_A_MASK   8'h0A

// field positions
`define EIF_REQ_PIN0 0
`define EIF_REQ_PIN1 1
`define EIF_REQ_EVT  2
`define EIF_PM_FUNC  0
`define EIF_EDGE_P0  0
`define EIF_EDGE_P1  1
`define EIF_IEN_EVT  2
`define EIF_ST_PIN0  0
`define EIF_ST_PIN1  1
`define EIF_ST_EVT   2
`define EIF_ST_WKP   3
`define EIF_ST_SPUR  4
`define EIF_ST_LOST  5

// reset values
`define EIF_RST_BYTE 8'h00
`define EIF_RST_WORD 16'h0000

`endif

// ---- rtl/eif_pkg.sv ----
// eif types: event edge modes and the block state
package eif_pkg;

    typedef enum logic [1:0] {AE_FALL, AE_RISE, AE_BOTH, AE_BOTH_ALT} eif_aedge_e;

    typedef struct packed {
        logic [10:0] sync1;
        logic [10:0] sync2;
        logic [10:0] prev;
        logic [2:0]  req1;
        logic [7:0]  wkreq;
        logic        pmb;
        logic        pm2;
        logic [7:0]  pm5;
        logic [1:0]  edge_sel;
        eif_aedge_e  aedge;
        logic [3:0]  ien;
        logic [7:0]  wkedge;
        logic [5:0]  stat;
        logic [5:0]  mask;
        logic        pm_last;
        logic [7:0]  rdata;
        logic        irq;
        logic [15:0] mem_addr;
        logic [15:0] stack_wdata;
        logic [7:0]  condition_code_reg;
    } eif_state_s;

endpackage

// ---- rtl/eif_top.sv ----
// eif external interrupt request flags, port mode switching and stack word handling
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "eif_map.svh"

module eif_top
    import eif_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,

    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,

    // external interrupt pins
    input  wire logic [7:0]  wakeup_pin_n,
    input  wire logic        ext_int_pin0_n,
    input  wire logic        ext_int_pin1_n,
    input  wire logic        async_event_int_pin,

    // interrupt output
    output logic             irq,

    // word access alignment
    input  wire logic        word_access,
    input  wire logic [15:0] access_addr,
    output logic      [15:0] mem_addr,

    // condition code stacking
    input  wire logic        ccr_save,
    input  wire logic [7:0]  ccr_value,
    output logic      [15:0] stack_wdata,
    input  wire logic        rte_restore,
    input  wire logic [15:0] stack_rdata,
    output logic      [7:0]  ccr_restored
);

    // pin vector layout: [7:0] wakeup, [8] pin0, [9] pin1, [10] event
    localparam int P0  = 8;
    localparam int P1  = 9;
    localparam int EVT = 10;

    eif_state_s q;
    eif_state_s d;

    // edge of a synchronised level, sense chosen by rise
    function automatic logic edge_hit(
        input logic prv,
        input logic cur,
        input logic rise
    );
        edge_hit = rise ? (!prv && cur) : (prv && !cur);
    endfunction

    // false request caused by switching a pin function while it is low
    function automatic logic switch_set(
        input logic old_fn,
        input logic new_fn,
        input logic low,
        input logic rise
    );
        logic up;
        logic down;
        up   = !old_fn && new_fn;
        down = old_fn && !new_fn;
        switch_set = low && (rise ? down : up);
    endfunction

    // register strobes decoded once
    logic wr_req1;
    logic wr_wkreq;
    logic wr_pmb;
    logic wr_pm2;
    logic wr_pm5;
    logic wr_stat;
    logic pm_hit;
    logic any_acc;

    assign wr_req1  = reg_wr && (reg_addr == `EIF_A_REQ1);
    assign wr_wkreq = reg_wr && (reg_addr == `EIF_A_WKREQ);
    assign wr_pmb   = reg_wr && (reg_addr == `EIF_A_PMB);
    assign wr_pm2   = reg_wr && (reg_addr == `EIF_A_PM2);
    assign wr_pm5   = reg_wr && (reg_addr == `EIF_A_PM5);
    assign wr_stat  = reg_wr && (reg_addr == `EIF_A_STAT);

    // a read of a port mode register counts as an access too
    assign pm_hit  = (reg_addr == `EIF_A_PMB) || (reg_addr == `EIF_A_PM2)
                  || (reg_addr == `EIF_A_PM5);
    assign any_acc = reg_wr || reg_rd;

    // wakeup flag sources, one slice per pin
    logic [7:0] wk_spur;
    logic [7:0] wk_edge;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_wkp
            // only 0 to 1 counts here, whatever the edge select
            assign wk_spur[gi] = wr_pm5
                && switch_set(q.pm5[gi], reg_wdata[gi], !q.sync2[gi], 1'b0);
            assign wk_edge[gi] = q.pm5[gi]
                && edge_hit(q.prev[gi], q.sync2[gi], q.wkedge[gi]);
        end
    endgenerate

    // pin0 and pin1 sources
    logic spur0;
    logic spur1;
    logic hit0;
    logic hit1;
    logic hit_evt;

    // falling sense arms the 0 to 1 case, rising sense the 1 to 0 case
    assign spur0 = wr_pm2 && switch_set(q.pm2, reg_wdata[`EIF_PM_FUNC],
                   !q.sync2[P0], q.edge_sel[`EIF_EDGE_P0]);
    assign spur1 = wr_pmb && switch_set(q.pmb, reg_wdata[`EIF_PM_FUNC],
                   !q.sync2[P1], q.edge_sel[`EIF_EDGE_P1]);

    // normal edge sensing while the pin has its interrupt function
    assign hit0 = q.pm2 && edge_hit(q.prev[P0], q.sync2[P0],
                  q.edge_sel[`EIF_EDGE_P0]);
    assign hit1 = q.pmb && edge_hit(q.prev[P1], q.sync2[P1],
                  q.edge_sel[`EIF_EDGE_P1]);

    // event pin: falling, rising or both, gated by its enable
    always_comb begin
        hit_evt = 1'b0;
        case (q.aedge)
            AE_FALL: begin
                hit_evt = q.prev[EVT] && !q.sync2[EVT];
            end
            AE_RISE: begin
                hit_evt = !q.prev[EVT] && q.sync2[EVT];
            end
            default: begin
                hit_evt = q.prev[EVT] ^ q.sync2[EVT];
            end
        endcase
        hit_evt = hit_evt && q.ien[`EIF_IEN_EVT];
    end

    // request flag clears are refused in the access right after a port mode access
    logic       clr_ok;
    logic [2:0] set1;
    logic [7:0] setw;

    assign clr_ok = !q.pm_last;
    assign set1   = {hit_evt, hit1 || spur1, hit0 || spur0};
    assign setw   = wk_spur | wk_edge;

    // next state
    always_comb begin
        d = q;

        // two flops before any detection reads a pin
        d.sync1 = {async_event_int_pin, ext_int_pin1_n, ext_int_pin0_n, wakeup_pin_n};
        d.sync2 = q.sync1;
        d.prev  = q.sync2;

        // control register writes
        if (wr_pmb) begin
            d.pmb = reg_wdata[`EIF_PM_FUNC];
        end
        if (wr_pm2) begin
            d.pm2 = reg_wdata[`EIF_PM_FUNC];
        end
        if (wr_pm5) begin
            d.pm5 = reg_wdata;
        end
        if (reg_wr && (reg_addr == `EIF_A_EDGE)) begin
            d.edge_sel = reg_wdata[1:0];
        end
        if (reg_wr && (reg_addr == `EIF_A_AEDGE)) begin
            d.aedge = eif_aedge_e'(reg_wdata[1:0]);
        end
        if (reg_wr && (reg_addr == `EIF_A_IEN1)) begin
            d.ien = reg_wdata[3:0];
        end
        if (reg_wr && (reg_addr == `EIF_A_WKEDGE)) begin
            d.wkedge = reg_wdata;
        end
        if (reg_wr && (reg_addr == `EIF_A_MASK)) begin
            d.mask = reg_wdata[5:0];
        end

        // zero bits clear, one bits keep; a flag set since the last
        // read is cleared too, which is why software must not
        // read-modify-write these registers
        if (wr_req1 && clr_ok) begin
            d.req1 = q.req1 & reg_wdata[2:0];
        end
        if (wr_wkreq && clr_ok) begin
            d.wkreq = q.wkreq & reg_wdata;
        end

        // new requests land after the clear, so one arriving in the clearing cycle is kept
        d.req1  = d.req1 | set1;
        d.wkreq = d.wkreq | setw;

        // remember whether this access touched a port mode register
        if (any_acc) begin
            d.pm_last = pm_hit;
        end

        // sticky status: write one to clear, new events win
        if (wr_stat) begin
            d.stat = q.stat & ~reg_wdata[5:0];
        end
        d.stat[`EIF_ST_PIN0] = d.stat[`EIF_ST_PIN0] | set1[0];
        d.stat[`EIF_ST_PIN1] = d.stat[`EIF_ST_PIN1] | set1[1];
        d.stat[`EIF_ST_EVT]  = d.stat[`EIF_ST_EVT] | set1[2];
        d.stat[`EIF_ST_WKP]  = d.stat[`EIF_ST_WKP] | (|setw);
        d.stat[`EIF_ST_SPUR] = d.stat[`EIF_ST_SPUR] | spur0 | spur1 | (|wk_spur);
        d.stat[`EIF_ST_LOST] = d.stat[`EIF_ST_LOST]
                             | ((wr_req1 || wr_wkreq) && !clr_ok);

        // level interrupt from the next status and mask, registered in the same edge as them
        d.irq = |(d.stat & d.mask);

        // read data stands only in the cycle after the read strobe
        d.rdata = `EIF_RST_BYTE;
        if (reg_rd) begin
            if (reg_addr == `EIF_A_REQ1) begin
                d.rdata = {5'h0, q.req1};
            end else if (reg_addr == `EIF_A_WKREQ) begin
                d.rdata = q.wkreq;
            end else if (reg_addr == `EIF_A_PMB) begin
                d.rdata = {7'h0, q.pmb};
            end else if (reg_addr == `EIF_A_PM2) begin
                d.rdata = {7'h0, q.pm2};
            end else if (reg_addr == `EIF_A_PM5) begin
                d.rdata = q.pm5;
            end else if (reg_addr == `EIF_A_EDGE) begin
                d.rdata = {6'h0, q.edge_sel};
            end else if (reg_addr == `EIF_A_AEDGE) begin
                d.rdata = {6'h0, q.aedge};
            end else if (reg_addr == `EIF_A_IEN1) begin
                d.rdata = {4'h0, q.ien};
            end else if (reg_addr == `EIF_A_WKEDGE) begin
                d.rdata = q.wkedge;
            end else if (reg_addr == `EIF_A_STAT) begin
                d.rdata = {2'h0, q.stat};
            end else if (reg_addr == `EIF_A_MASK) begin
                d.rdata = {2'h0, q.mask};
            end else begin
                d.rdata = `EIF_RST_BYTE; // unmapped reads zero
            end
        end

        // word accesses ignore address bit zero, so an odd stack
        // pointer silently lands one byte low
        if (word_access) begin
            d.mem_addr = {access_addr[15:1], 1'b0};
        end else begin
            d.mem_addr = access_addr;
        end

        // both bytes of the word carry the condition codes
        if (ccr_save) begin
            d.stack_wdata = {ccr_value, ccr_value};
        end

        // even address is the high byte; the odd byte is dropped
        if (rte_restore) begin
            d.condition_code_reg = stack_rdata[15:8];
        end
    end

    // state register; all control clears to zero at reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q.sync1       <= 11'h7FF;
            q.sync2       <= 11'h7FF;
            q.prev        <= 11'h7FF;
            q.req1        <= 3'h0;
            q.wkreq       <= `EIF_RST_BYTE;
            q.pmb         <= 1'b0;
            q.pm2         <= 1'b0;
            q.pm5         <= `EIF_RST_BYTE;
            q.edge_sel    <= 2'h0;
            q.aedge       <= AE_FALL;
            q.ien         <= 4'h0;
            q.wkedge      <= `EIF_RST_BYTE;
            q.stat        <= 6'h00;
            q.mask        <= 6'h00;
            q.pm_last     <= 1'b0;
            q.rdata       <= `EIF_RST_BYTE;
            q.irq         <= 1'b0;
            q.mem_addr    <= `EIF_RST_WORD;
            q.stack_wdata <= `EIF_RST_WORD;
            q.condition_code_reg         <= `EIF_RST_BYTE;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign reg_rdata    = q.rdata;
    assign irq          = q.irq;
    assign mem_addr     = q.mem_addr;
    assign stack_wdata  = q.stack_wdata;
    assign ccr_restored = q.condition_code_reg;

endmodule

// ---- test/eif_asserts.sv ----
// port timing checker for the eif block
`timescale 1ns/1ps
`include "eif_map.svh"

module eif_asserts (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        irq,
    // stack side
    input wire logic        word_access,
    input wire logic [15:0] access_addr,
    input wire logic [15:0] mem_addr,
    input wire logic        ccr_save,
    input wire logic [7:0]  ccr_value,
    input wire logic [15:0] stack_wdata,
    input wire logic        rte_restore,
    input wire logic [15:0] stack_rdata,
    input wire logic [7:0]  ccr_restored
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // mask writes, used to bound the irq drop
    wire mask_wr = reg_wr && (reg_addr == `EIF_A_MASK);

    // read data only in the cycle after a read strobe
    a_rdata_idle: assert property ($past(reg_rd) == 1'b0 |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_word_align: assert property (word_access |=> mem_addr == {$past(access_addr[15:1]), 1'b0})
        else $error("word address bit0 not cleared");
    a_byte_pass: assert property (!word_access |=> mem_addr == $past(access_addr))
        else $error("byte address altered");
    a_ccr_word: assert property (ccr_save |=> stack_wdata == {2{$past(ccr_value)}})
        else $error("condition codes not saved as a word");
    a_ccr_even: assert property (rte_restore |=> ccr_restored == $past(stack_rdata[15:8]))
        else $error("condition codes not taken from even byte");
    a_ccr_hold: assert property (!rte_restore |=> $stable(ccr_restored))
        else $error("restored codes changed without restore");
    a_stack_hold: assert property (!ccr_save |=> $stable(stack_wdata))
        else $error("stack word changed without save");
    // irq may lag the mask by one register stage
    a_irq_masked: assert property (mask_wr && reg_wdata == 8'h00 ##1 !mask_wr |=> !irq)
        else $error("irq high with all sources masked");

    // main scenarios
    c_save: cover property (ccr_save && rte_restore);
    c_odd: cover property (word_access && access_addr[0]);
    c_irq: cover property ($rose(irq));
endmodule

bind eif_top eif_asserts u_chk (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .word_access, .access_addr, .mem_addr, .ccr_save, .ccr_value, .stack_wdata, .rte_restore,
    .stack_rdata, .ccr_restored);

// ---- test/eif_pin_model.sv ----
// pin-side model: drives the interrupt pins from requested levels
`timescale 1ns/1ps

module eif_pin_model (
    // clock and requested levels
    input wire logic        sys_clk,
    input wire logic [10:0] lvl,
    // pins
    output logic     [7:0]  wakeup_pin_n,
    output logic            ext_int_pin0_n,
    output logic            ext_int_pin1_n,
    output logic            async_event_int_pin
);
    // levels move just after an edge, like a clocked source; one driver per pin,
    // and the bench starts every low-active pin high so a switch finds a low pin only after the bench drives that pin low
    always @(posedge sys_clk) begin
        {async_event_int_pin, ext_int_pin1_n, ext_int_pin0_n, wakeup_pin_n} <= lvl;
    end
endmodule

// ---- test/eif_top_test.sv ----
// self-checking bench for the eif flag logic
`timescale 1ns/1ps
`include "eif_map.svh"

module eif_top_test;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [10:0] lvl = 11'h3FF;
    logic [7:0]  wk_n;
    logic        p0_n;
    logic        p1_n;
    logic        evt;
    logic        irq;
    logic        word_access = 1'b0;
    logic [15:0] access_addr = 16'h0000;
    logic [15:0] mem_addr;
    logic        ccr_save = 1'b0;
    logic [7:0]  ccr_value = 8'h00;
    logic [15:0] stack_wdata;
    logic        rte_restore = 1'b0;
    logic [15:0] stack_rdata = 16'h0000;
    logic [7:0]  ccr_restored;
    int          errors = 0;
    int          n_tests = 0;

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    eif_pin_model PINS (.sys_clk, .lvl, .wakeup_pin_n(wk_n), .ext_int_pin0_n(p0_n), .ext_int_pin1_n(p1_n),
        .async_event_int_pin(evt));
    eif_top DUT (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wakeup_pin_n(wk_n),
        .ext_int_pin0_n(p0_n), .ext_int_pin1_n(p1_n), .async_event_int_pin(evt), .irq, .word_access,
        .access_addr, .mem_addr, .ccr_save, .ccr_value, .stack_wdata, .rte_restore, .stack_rdata, .ccr_restored);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // one-cycle strobes; the idle cycle after each keeps drivers clean
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // pin change, then wait out model stage and two-flop sync
    task automatic pin(input int b, input logic v);
        @(posedge sys_clk);
        lvl[b] <= v;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        close_out;
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 12; a++) rd(a[7:0], 8'h00);
        wr(`EIF_A_MASK, 8'h3F);
        // wakeup switch with pin low, clear right after is refused
        pin(0, 1'b0);
        wr(`EIF_A_PM5, 8'h01);
        wr(`EIF_A_WKREQ, 8'hFE);
        rd(`EIF_A_WKREQ, 8'h01);
        rd(`EIF_A_STAT, 8'h38);
        chk({15'h0000, irq}, 16'h0001);
        wr(`EIF_A_WKREQ, 8'hFE);
        rd(`EIF_A_WKREQ, 8'h00);
        wr(`EIF_A_MASK, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        // pin0 switched on while low with falling sense
        pin(8, 1'b0);
        wr(`EIF_A_PM2, 8'h01);
        rd(`EIF_A_EDGE, 8'h00);
        rd(`EIF_A_REQ1, 8'h01);
        // pin1 rising sense: a fall is ignored, switching off while low sets
        wr(`EIF_A_EDGE, 8'h02);
        wr(`EIF_A_PMB, 8'h01);
        pin(9, 1'b0);
        rd(`EIF_A_REQ1, 8'h01);
        wr(`EIF_A_PMB, 8'h00);
        rd(`EIF_A_AEDGE, 8'h00);
        rd(`EIF_A_REQ1, 8'h03);
        // event set after a read is lost to a stale zero write
        wr(`EIF_A_AEDGE, 8'h01);
        wr(`EIF_A_IEN1, 8'h04);
        rd(`EIF_A_REQ1, 8'h03);
        pin(10, 1'b1);
        wr(`EIF_A_REQ1, 8'h01);
        rd(`EIF_A_REQ1, 8'h01);
        // falling sense, then enable off blocks the event flag
        wr(`EIF_A_AEDGE, 8'h00);
        pin(10, 1'b0);
        rd(`EIF_A_REQ1, 8'h05);
        wr(`EIF_A_IEN1, 8'h00);
        wr(`EIF_A_REQ1, 8'hFB);
        pin(10, 1'b1);
        pin(10, 1'b0);
        rd(`EIF_A_REQ1, 8'h01);
        // both-edge event sense sets the flag on a rise and again on a fall
        wr(`EIF_A_AEDGE, 8'h02);
        wr(`EIF_A_IEN1, 8'h04);
        pin(10, 1'b1);
        rd(`EIF_A_REQ1, 8'h05);
        wr(`EIF_A_REQ1, 8'hFB);
        pin(10, 1'b0);
        rd(`EIF_A_REQ1, 8'h05);
        // wakeup pin 1 switched on while high, then rising sense only
        wr(`EIF_A_PM5, 8'h03);
        wr(`EIF_A_WKEDGE, 8'h02);
        pin(1, 1'b0);
        rd(`EIF_A_WKREQ, 8'h00);
        pin(1, 1'b1);
        rd(`EIF_A_WKREQ, 8'h02);
        // status bits clear by writing ones
        wr(`EIF_A_STAT, 8'h3F);
        rd(`EIF_A_STAT, 8'h00);
        // odd word address, condition code save and restore
        @(posedge sys_clk);
        word_access <= 1'b1;
        access_addr <= 16'h1235;
        ccr_save <= 1'b1;
        ccr_value <= 8'hA5;
        rte_restore <= 1'b1;
        stack_rdata <= 16'h3CC3;
        @(posedge sys_clk);
        word_access <= 1'b0;
        ccr_save <= 1'b0;
        rte_restore <= 1'b0;
        #1;
        chk(mem_addr, 16'h1234);
        chk(stack_wdata, 16'hA5A5);
        chk({8'h00, ccr_restored}, 16'h003C);
        @(posedge sys_clk);
        #1;
        chk(mem_addr, 16'h1235);
        // reset in mid-run: flags, status and stacked values return to zero;
        // the address goes idle in the same cycle as reset so the held address checks stay true
        @(posedge sys_clk);
        access_addr <= 16'h0000;
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`EIF_A_REQ1, 8'h00);
        rd(`EIF_A_WKREQ, 8'h00);
        rd(`EIF_A_STAT, 8'h00);
        chk(stack_wdata, 16'h0000);
        chk({8'h00, ccr_restored}, 16'h0000);
        close_out;
    end
endmodule
